// file: design/pin_change_interrupt.sv
// What this block does
// RQ1: Every implemented pin can raise an edge interrupt, alone or combined, either direction.
// RQ2: changeIrq is gated by master enable, irq is not; detection and flags keep working when clear.
// RQ3: Each pin has a rising detector armed only by its rise enable bit.
// RQ4: Each pin has a falling detector armed only by its fall enable bit.
// RQ5: Both enables set means edges of both directions are caught.
// RQ6: An enabled edge sets the pin's sticky flag until software clears it.
// RQ7: Summary flag in control register is the OR of all pin flags.
// RQ8: Writing zero clears a flag, but an edge during the write keeps it set.
// RQ9: Software should clear flags only by masking off flags already seen.
// RQ10: With master enable set, a detected enabled edge wakes the device from sleep.
// RQ11: An edge seen in sleep is in the flag register from the same clock edge that signals wake.
// RQ12: First port uses bits 5..0; upper bits read zero.
// RQ13: Second port, when present, uses bits 7..4; lower bits read zero.
// RQ14: Pins are synchronised, edges found by comparing current and previous samples.
`timescale 1ns/1ps
`default_nettype none

module pin_change_interrupt
	import pin_change_interrupt_pkg::*;
(
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	// Wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [ADDR_WIDTH-1:0] wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// Port pins
	input  wire logic [PORT_WIDTH-1:0] firstPortPins,
	input  wire logic [PORT_WIDTH-1:0] secondPortPins,
	input  wire logic [PORT_WIDTH-1:0] thirdPortPins,
	// Core side
	input  wire logic                  sleepMode,
	output logic                       changeIrq,
	output logic                       wakeReq,
	output logic                       irq
);

	// ----------------------------------------
	// Types and helpers
	// ----------------------------------------
	typedef logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] port_vec_t;

	typedef struct packed {
		port_vec_t   syncFirst;
		port_vec_t   syncSecond;
		port_vec_t   prevSample;
		port_vec_t   riseEnable;
		port_vec_t   fallEnable;
		port_vec_t   changeFlag;
		logic [1:0]  primeCnt;
		logic        masterEnable;
		logic [2:0]  irqStatus;
		logic [2:0]  irqMask;
		logic        ack;
		logic [31:0] readData;
		logic        wake;
	} state_s;

	// Implemented bits of each port
	function automatic logic [7:0] portMask(input int p);
		logic [7:0] m;
		m = THIRD_PORT_MASK;
		if (p == FIRST_PORT) begin
			m = FIRST_PORT_MASK; // see RQ12
		end else if (p == SECOND_PORT) begin
			m = SECOND_PORT_PRESENT ? SECOND_PORT_MASK : PORT_RESET; // see RQ13
		end
		return m;
	endfunction

	function automatic reg_sel_e regSel(input logic [ADDR_WIDTH-1:0] a);
		reg_sel_e s;
		s = SEL_NONE;
		if (a == INTERRUPT_CONTROL_ADDR) begin
			s = SEL_CTRL;
		end else if (a == IRQ_STATUS_ADDR) begin
			s = SEL_STAT;
		end else if (a == IRQ_MASK_ADDR) begin
			s = SEL_MASK;
		end else if (a < 8'(NUM_PORTS) * PORT_STRIDE) begin
			unique case (a[3:0])
				RISE_ENABLE_OFS: s = SEL_RISE;
				FALL_ENABLE_OFS: s = SEL_FALL;
				CHANGE_FLAG_OFS: s = SEL_FLAG;
				default:         s = SEL_NONE;
			endcase
		end
		return s;
	endfunction

	function automatic int portIndex(input logic [ADDR_WIDTH-1:0] a);
		return int'(a[5:4]);
	endfunction

	state_s    cur_q;
	state_s    nxt_d;
	port_vec_t pinsIn;
	port_vec_t riseHit;
	port_vec_t fallHit;
	port_vec_t edgeHit;

	assign pinsIn[FIRST_PORT]  = firstPortPins;
	assign pinsIn[SECOND_PORT] = secondPortPins;
	assign pinsIn[THIRD_PORT]  = thirdPortPins;

	// ----------------------------------------
	// Edge detectors
	// ----------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : gen_edge
			// see RQ3
			assign riseHit[gp] = cur_q.syncSecond[gp] & ~cur_q.prevSample[gp] & cur_q.riseEnable[gp];
			// see RQ4
			assign fallHit[gp] = ~cur_q.syncSecond[gp] & cur_q.prevSample[gp] & cur_q.fallEnable[gp];
			// Detection waits until primeCnt reaches PRIME_CYCLES, when syncSecond holds a real sample but prevSample
			// still holds the reset zero, so a pin high at reset can still fake a rising edge. see RQ5 RQ1
			assign edgeHit[gp] = (riseHit[gp] | fallHit[gp]) & portMask(gp) & {PORT_WIDTH{cur_q.primeCnt == PRIME_CYCLES}};
		end
	endgenerate

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		reg_sel_e  sel;
		int        pi;
		logic      access;
		logic      doWrite;
		logic [7:0] wbyte;
		logic [7:0] rbyte;
		logic      summary;
		logic [2:0] portEvent;

		nxt_d     = cur_q;
		sel       = regSel(wb_adr_i);
		pi        = portIndex(wb_adr_i);
		access    = wb_cyc_i & wb_stb_i & ~cur_q.ack;
		doWrite   = access & wb_we_i & wb_sel_i[0];
		wbyte     = wb_dat_i[7:0];
		rbyte     = 8'h00;
		summary   = |cur_q.changeFlag; // see RQ7
		portEvent = 3'h0;

		// Two-stage synchroniser then one history stage. see RQ14
		nxt_d.syncFirst  = pinsIn;
		nxt_d.syncSecond = cur_q.syncFirst;
		nxt_d.prevSample = cur_q.syncSecond;
		if (cur_q.primeCnt != PRIME_CYCLES) begin
			nxt_d.primeCnt = cur_q.primeCnt + 2'h1;
		end

		// Register writes
		if (doWrite) begin
			unique case (sel)
				SEL_RISE: nxt_d.riseEnable[pi] = wbyte & portMask(pi);
				SEL_FALL: nxt_d.fallEnable[pi] = wbyte & portMask(pi);
				SEL_FLAG: nxt_d.changeFlag[pi] = wbyte & portMask(pi); // see RQ8
				SEL_CTRL: nxt_d.masterEnable   = wbyte[CTRL_MASTER_ENABLE_BIT];
				SEL_MASK: nxt_d.irqMask        = wbyte[2:0];
				SEL_STAT,
				SEL_NONE: ;
			endcase
		end

		// Reads
		unique case (sel)
			SEL_RISE: rbyte = cur_q.riseEnable[pi] & portMask(pi);
			SEL_FALL: rbyte = cur_q.fallEnable[pi] & portMask(pi);
			SEL_FLAG: rbyte = cur_q.changeFlag[pi] & portMask(pi);
			SEL_CTRL: begin
				rbyte[CTRL_MASTER_ENABLE_BIT] = cur_q.masterEnable;
				rbyte[CTRL_SUMMARY_FLAG_BIT]  = summary;
			end
			SEL_STAT: rbyte = {5'h00, cur_q.irqStatus};
			SEL_MASK: rbyte = {5'h00, cur_q.irqMask};
			SEL_NONE: rbyte = 8'h00;
		endcase

		// Read of the status register clears it
		if (access & ~wb_we_i & (sel == SEL_STAT)) begin
			nxt_d.irqStatus = IRQ_RESET;
		end

		// Edges come last so that a set beats any clearing write. see RQ6 RQ8
		for (int p = 0; p < NUM_PORTS; p++) begin
			nxt_d.changeFlag[p] = nxt_d.changeFlag[p] | edgeHit[p];
			portEvent[p]        = |edgeHit[p];
		end
		nxt_d.irqStatus = nxt_d.irqStatus | portEvent;

		// Wake pulse rises on the same edge that stores the flag, so the flag is
		// already readable when the core resumes. see RQ10 RQ11
		nxt_d.wake = sleepMode & cur_q.masterEnable & (|portEvent);

		// Classic Wishbone: one-cycle answer, every address acknowledged
		nxt_d.ack      = access;
		nxt_d.readData = access ? {24'h000000, rbyte} : BUS_DATA_RESET;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cur_q.syncFirst    <= '0;
			cur_q.syncSecond   <= '0;
			cur_q.prevSample   <= '0;
			cur_q.riseEnable   <= '0;
			cur_q.fallEnable   <= '0;
			cur_q.changeFlag   <= '0;
			cur_q.primeCnt     <= 2'h0;
			cur_q.masterEnable <= 1'b0;
			cur_q.irqStatus    <= IRQ_RESET;
			cur_q.irqMask      <= IRQ_RESET;
			cur_q.ack          <= 1'b0;
			cur_q.readData     <= BUS_DATA_RESET;
			cur_q.wake         <= 1'b0;
		end else begin
			cur_q <= nxt_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_ack_o  = cur_q.ack;
	assign wb_dat_o  = cur_q.readData;
	assign changeIrq = cur_q.masterEnable & (|cur_q.changeFlag); // see RQ2
	assign wakeReq   = cur_q.wake;
	assign irq       = |(cur_q.irqStatus & cur_q.irqMask);

endmodule

`default_nettype wire

// file: inc/pin_change_interrupt_pkg.sv
package pin_change_interrupt_pkg;

	// ----------------------------------------
	// Port geometry
	// ----------------------------------------
	localparam int         NUM_PORTS   = 3;
	localparam int         PORT_WIDTH  = 8;
	localparam int         FIRST_PORT  = 0;
	localparam int         SECOND_PORT = 1;
	localparam int         THIRD_PORT  = 2;
	// Second port exists only on the larger variants
	localparam logic       SECOND_PORT_PRESENT = 1'b1;
	localparam logic [7:0] FIRST_PORT_MASK     = 8'h3F;
	localparam logic [7:0] SECOND_PORT_MASK    = 8'hF0;
	localparam logic [7:0] THIRD_PORT_MASK     = 8'hFF;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam int         ADDR_WIDTH      = 8;
	localparam logic [7:0] PORT_STRIDE     = 8'h10;
	localparam logic [3:0] RISE_ENABLE_OFS = 4'h0;
	localparam logic [3:0] FALL_ENABLE_OFS = 4'h4;
	localparam logic [3:0] CHANGE_FLAG_OFS = 4'h8;
	localparam logic [7:0] INTERRUPT_CONTROL_ADDR = 8'h30;
	localparam logic [7:0] IRQ_STATUS_ADDR        = 8'h34;
	localparam logic [7:0] IRQ_MASK_ADDR          = 8'h38;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int          CTRL_MASTER_ENABLE_BIT = 0;
	localparam int          CTRL_SUMMARY_FLAG_BIT  = 1;
	localparam logic [7:0]  PORT_RESET       = 8'h00;
	localparam logic [2:0]  IRQ_RESET        = 3'h0;
	localparam logic [31:0] BUS_DATA_RESET   = 32'h00000000;
	localparam logic [1:0]  PRIME_CYCLES     = 2'h2;

	// ----------------------------------------
	// Register selector
	// ----------------------------------------
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_RISE,
		SEL_FALL,
		SEL_FLAG,
		SEL_CTRL,
		SEL_STAT,
		SEL_MASK
	} reg_sel_e;

endpackage

// file: bench/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Sleep handshake
	input  wire logic goSleep,
	input  wire logic wakeReq,
	output var logic  sleepMode
);
	// -----------
	// Sleep state
	// -----------
	// Only wakeReq from the block or sys_rst can end sleep here, so a missing wake leaves sleepMode stuck high
	always_ff @(posedge ref_clk) begin
		if (sys_rst || wakeReq) sleepMode <= 1'b0;
		else if (goSleep) sleepMode <= 1'b1;
	end
endmodule
`default_nettype wire

// file: bench/pin_change_interrupt_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt_chk
	import pin_change_interrupt_pkg::*;
(
	// Clock and reset
	input wire logic                  ref_clk,
	input wire logic                  sys_rst,
	// Bus
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	// Pins and core side
	input wire logic [PORT_WIDTH-1:0] firstPortPins,
	input wire logic [PORT_WIDTH-1:0] secondPortPins,
	input wire logic [PORT_WIDTH-1:0] thirdPortPins,
	input wire logic                  sleepMode,
	input wire logic                  changeIrq,
	input wire logic                  wakeReq,
	input wire logic                  irq
);
	// ----------
	// Properties
	// ----------
	wire logic [23:0] allPins = {firstPortPins, secondPortPins, thirdPortPins};
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	chk_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
	chk_dat_upper: assert property (wb_dat_o[31:8] == 24'h0) else $error("upper data set");
	chk_flag_cause: assert property ($rose(changeIrq) && !wb_ack_o |->
		$past(allPins, 3) != $past(allPins, 4)) else $error("flag without edge");
	chk_irq_cause: assert property ($rose(irq) && !wb_ack_o |->
		$past(allPins, 3) != $past(allPins, 4)) else $error("irq without edge");
	chk_change_fall: assert property ($fell(changeIrq) |-> wb_ack_o) else $error("flag lost");
	chk_irq_fall: assert property ($fell(irq) |-> wb_ack_o) else $error("irq lost");
	chk_wake_gate: assert property (wakeReq |-> changeIrq && $past(sleepMode)) else $error("bad wake");
	chk_reset_quiet: assert property (disable iff (1'b0)
		sys_rst |=> !wb_ack_o && !changeIrq && !irq && !wakeReq) else $error("reset not quiet");
endmodule
bind pin_change_interrupt pin_change_interrupt_chk chk_u (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
	.wb_ack_o, .firstPortPins, .secondPortPins, .thirdPortPins, .sleepMode, .changeIrq, .wakeReq, .irq);
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import pin_change_interrupt_pkg::*; ;
	// -------
	// Signals
	// -------
	logic        ref_clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, we = 1'b0, goSleep = 1'b0;
	logic [7:0]  adr = 8'h00, dat = 8'h00, pinA = 8'h00, pinB = 8'h00, pinC = 8'h00;
	logic [31:0] rdat, datO;
	logic        ack, changeIrq, wakeReq, irq, sleepMode;
	int          numErrors = 0, cmpCount = 0;
	always #5 ref_clk = ~ref_clk;
	pin_change_interrupt dut_u (.ref_clk, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i({24'h0, dat}), .wb_dat_o(datO), .wb_ack_o(ack), .firstPortPins(pinA),
		.secondPortPins(pinB), .thirdPortPins(pinC), .sleepMode, .changeIrq, .wakeReq, .irq);
	core_model core_u (.ref_clk, .sys_rst, .goSleep, .wakeReq, .sleepMode);
	// -----
	// Tasks
	// -----
	task automatic check(input logic [31:0] seen, exp);
		cmpCount++;
		if (seen !== exp) begin
			numErrors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic printVerdict;
		$display("Compares %0d, errors %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Ack and data are taken at the rising edge that samples ack high, and the request drops on that edge
	task automatic wb(input logic w, input logic [7:0] a, d);
		int n;
		n = 0;
		@(posedge ref_clk) {cyc, we, adr, dat} <= {1'b1, w, a, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = datO;
		cyc <= 1'b0;
		if (n >= 50) begin
			check(ack, 1'b1);
			printVerdict();
		end
	endtask
	task automatic tRegs;
		logic [7:0] m[3];
		m = '{8'h3F, 8'hF0, 8'hFF};
		for (int p = 0; p < 3; p++) begin
			wb(1'b0, 8'(p * 16 + 8), 8'h00);
			check(rdat, 32'h0);
			wb(1'b1, 8'(p * 16 + 4), 8'hFF);
			wb(1'b0, 8'(p * 16 + 4), 8'h00);
			check(rdat, {24'h0, m[p]});
		end
		wb(1'b0, 8'h3C, 8'h00);
		check(rdat, 32'h0);
	endtask
	task automatic tEdges;
		wb(1'b1, 8'h00, 8'h05);
		wb(1'b1, 8'h04, 8'h06);
		@(posedge ref_clk) pinA <= 8'h07;
		repeat (4) @(posedge ref_clk);
		wb(1'b0, 8'h08, 8'h00);
		check(rdat, 32'h05);
		wb(1'b0, 8'h30, 8'h00);
		check(rdat, 32'h02);
		check(changeIrq, 1'b0);
		wb(1'b1, 8'h08, 8'h00);
		@(posedge ref_clk) pinA <= 8'h00;
		repeat (4) @(posedge ref_clk);
		wb(1'b0, 8'h08, 8'h00);
		check(rdat, 32'h06);
	endtask
	task automatic tIrq;
		wb(1'b1, 8'h30, 8'h01);
		check(changeIrq, 1'b1);
		wb(1'b1, 8'h38, 8'h01);
		check(irq, 1'b1);
		wb(1'b0, 8'h34, 8'h00);
		check(rdat, 32'h01);
		check(irq, 1'b0);
	endtask
	// The clearing write lands on the same edge that records the new rise
	task automatic tRace;
		@(posedge ref_clk) pinA <= 8'h01;
		repeat (1) @(posedge ref_clk);
		wb(1'b1, 8'h08, 8'h00);
		wb(1'b0, 8'h08, 8'h00);
		check(rdat, 32'h01);
	endtask
	task automatic tSleep;
		int n;
		n = 0;
		wb(1'b1, 8'h08, 8'h00);
		wb(1'b1, 8'h20, 8'h80);
		@(posedge ref_clk) goSleep <= 1'b1;
		@(posedge ref_clk) {goSleep, pinC} <= {1'b0, 8'h80};
		do begin
			@(negedge ref_clk);
			n++;
		end while (wakeReq !== 1'b1 && n < 20);
		check(wakeReq, 1'b1);
		if (n >= 20) printVerdict();
		check(changeIrq, 1'b1);
		@(negedge ref_clk);
		check(sleepMode, 1'b0);
	endtask
	task automatic tReset;
		@(posedge ref_clk) sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		wb(1'b0, 8'h28, 8'h00);
		check(rdat, 32'h0);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		tRegs();
		tEdges();
		tIrq();
		tRace();
		tSleep();
		tReset();
		printVerdict();
	end
endmodule
`default_nettype wire
